/* ibtl_pkg.sv */
// Package with constants, types and register map of the instrument bus talker/listener.
// What this block does
// RULE1: Five switch bits give address, 31 talk-only.
// RULE2: Switch value 31 selects unaddressed talk-only.
// RULE3: Factory preset switch address is decimal 10.
// RULE4: Loop controller keeps 0, assigns upward.
// RULE5: Remote, talk, listen indicators follow state.
// RULE6: Service indicator lit by masked conditions only.
// RULE7: Going local clears only remote indicator.
// RULE8: Talk indicator stays lit in talk-only.
// RULE9: Output format identical in both modes.
// RULE10: Enabled status bit raises service request.
// RULE11: Power-up in local; remote before programming.
// RULE12: Remote ignores panel; local key returns.
// RULE13: Lockout disables local key; NRE clears.
// RULE14: No parallel poll on bus; full on loop.
// RULE15: Device clear resets and clears display.
// RULE16: Trigger marks next measurement as triggered.
// RULE17: Listen addressing while talking leaves talker.
// RULE18: Talker answers poll, sends identifications.
// RULE19: Loop service request also via IDY frame.
// RULE20: Simple addresses only, never controller.
// RULE21: Remote power-down requests are ignored.
// RULE22: DDL enables or disables auto-addressing.
// RULE23: Commands are coded bytes; data ASCII.
// RULE24: Loop frames eleven bits; others pass on.
// RULE25: Indicators driven straight from state flags.
package ibtl_pkg;
    // Switch value that selects talk-only operation.
    localparam logic [4:0] IBTL_TALK_ONLY_ADDR = 5'h1f;
    // Factory preset switch address.
    localparam logic [4:0] IBTL_PRESET_ADDR = 5'h0a;
    // Loop frame width in bits.
    localparam int IBTL_FRAME_BITS = 11;
    // Register byte offsets.
    localparam logic [7:0] IBTL_CMD_OFS = 8'h00;
    localparam logic [7:0] IBTL_STAT_OFS = 8'h04;
    localparam logic [7:0] IBTL_MASK_OFS = 8'h08;
    localparam logic [7:0] IBTL_COND_OFS = 8'h0c;
    localparam logic [7:0] IBTL_FRAME_OFS = 8'h10;
    localparam logic [7:0] IBTL_CFG_OFS = 8'h14;
    // Reset values.
    localparam logic [7:0] IBTL_MASK_RST = 8'h00;
    localparam logic [1:0] IBTL_CFG_RST = 2'h1;
    // Command codes written to the command register.
    typedef enum logic [4:0] {
        IBTL_C_NOP = 5'h00, IBTL_C_LAD = 5'h01, IBTL_C_TAD = 5'h02,
        IBTL_C_UNL = 5'h03, IBTL_C_UNT = 5'h04, IBTL_C_REN = 5'h05,
        IBTL_C_GTL = 5'h06, IBTL_C_LLO = 5'h07, IBTL_C_NRE = 5'h08,
        IBTL_C_DCL = 5'h09, IBTL_C_SDC = 5'h0a, IBTL_C_GET = 5'h0b,
        IBTL_C_IFC = 5'h0c, IBTL_C_AAD = 5'h0d, IBTL_C_AAU = 5'h0e,
        IBTL_C_DDL = 5'h0f, IBTL_C_EAR = 5'h10, IBTL_C_ANOP = 5'h11,
        IBTL_C_PPE = 5'h12, IBTL_C_PPD = 5'h13, IBTL_C_PPU = 5'h14,
        IBTL_C_SST = 5'h15, IBTL_C_SDI = 5'h16, IBTL_C_SAI = 5'h17,
        IBTL_C_PDN = 5'h18
    } ibtl_cmd_t;
    // Indicator bundle driven to the front panel.
    typedef struct packed {
        logic remote;
        logic talk;
        logic listen;
        logic srq;
    } ibtl_led_t;
    // Loop output request bundle.
    typedef struct packed {
        logic idy;
        logic [1:0] send;
    } ibtl_req_t;
    // Send kinds used by the talker.
    localparam logic [1:0] IBTL_SEND_STATUS = 2'h1;
    localparam logic [1:0] IBTL_SEND_DEVID = 2'h2;
    localparam logic [1:0] IBTL_SEND_ACCID = 2'h3;
endpackage

/* ibtl_top.sv */
// Talker, listener, remote/local, service request and loop frame logic of the instrument.
`timescale 1ns/100ps
module ibtl_top import ibtl_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [4:0] addr_switch_i,
    input wire logic local_key_i,
    input wire logic panel_change_i,
    input wire logic loop_sel_i,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output ibtl_led_t led_o,
    output logic srq_line_o,
    output logic panel_accept_o,
    output logic dev_clear_o,
    output logic trig_pending_o,
    output ibtl_req_t loop_req_o,
    output logic [10:0] frame_out_o,
    output logic frame_out_valid_o
);
    // Reset synchroniser and switch/key synchronisers.
    logic rst_s1_q, rst_n;
    logic [6:0] pin_s1_q, pin_s2_q;
    // Interface state flags.
    logic remote_q, talk_q, listen_q, llo_q, ren_q, auto_en_q, auto_set_q, pp_en_q, ear_q;
    logic [4:0] auto_addr_q;
    logic [7:0] mask_q, cond_q;
    logic [10:0] frame_in_q;
    logic frame_pend_q;
    logic key_prev_q;
    // Bus address-phase capture, held for the data phase.
    logic wr_q;
    logic [7:0] wa_q;
    // Decoded command fields.
    ibtl_cmd_t cmd;
    logic [4:0] arg, my_addr;
    logic cmd_go, talk_only, key_rise, panel_ok, srq_now, addressed;

    // Reset is released through two flip-flops.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // Switch, key and panel pins pass two flip-flops before use.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= 7'h00;
            pin_s2_q <= 7'h00;
        end else begin
            pin_s1_q <= {panel_change_i, local_key_i, addr_switch_i};
            pin_s2_q <= pin_s1_q;
        end
    end

    // Switch value 31 selects talk-only, else the switch or auto address is used.
    assign talk_only = (pin_s2_q[4:0] == IBTL_TALK_ONLY_ADDR); // see RULE1 see RULE2
    assign my_addr = (auto_en_q && auto_set_q && loop_sel_i) ? auto_addr_q : pin_s2_q[4:0];
    assign key_rise = pin_s2_q[5] && !key_prev_q;
    // Write data phase into the command register carries a command code and argument.
    // The command is acted on in the data phase, one cycle after the address phase.
    // Nothing here waits, so the bus never needs a wait state for a command.
    assign cmd_go = wr_q && (wa_q == IBTL_CMD_OFS);
    // Interface commands arrive as coded words, never as character text.
    // Codes outside the table decode to nothing and are silently dropped.
    assign cmd = ibtl_cmd_t'(hwdata[4:0]); // see RULE23
    // The address or argument field sits in the second byte of the word.
    assign arg = hwdata[12:8];
    // Only simple five-bit addresses are matched; no secondary address exists.
    assign addressed = (arg == my_addr) && !talk_only; // see RULE20
    assign srq_now = |(cond_q & mask_q); // see RULE6 see RULE10
    assign panel_ok = !remote_q;

    // Key edge tracking.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            key_prev_q <= 1'b0;
        end else begin
            key_prev_q <= pin_s2_q[5];
        end
    end

    // AHB-Lite address phase capture; the slave is ready from the first clock after reset, responses OKAY.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
        end else if (hready) begin
            wr_q <= hsel && htrans[1] && hwrite;
            wa_q <= haddr;
        end else begin
            wr_q <= 1'b0;
        end
    end

    // Read data registered at the address phase; unmapped offsets read zero.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready && hsel && htrans[1] && !hwrite) begin
                unique case (haddr)
                    IBTL_STAT_OFS: hrdata <= {16'h0000, 3'h0, my_addr, llo_q, ren_q,
                        pp_en_q, ear_q, remote_q, talk_q, listen_q, srq_now};
                    IBTL_MASK_OFS: hrdata <= {24'h000000, mask_q};
                    IBTL_COND_OFS: hrdata <= {24'h000000, cond_q};
                    IBTL_FRAME_OFS: hrdata <= {20'h00000, frame_pend_q, frame_in_q};
                    IBTL_CFG_OFS: hrdata <= {30'h0, auto_set_q, auto_en_q};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Service mask and conditions; within one condition write a set bit wins over a clear bit.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= IBTL_MASK_RST;
            cond_q <= 8'h00;
        end else begin
            if (wr_q && wa_q == IBTL_MASK_OFS) begin
                mask_q <= hwdata[7:0];
            end
            if (wr_q && wa_q == IBTL_COND_OFS) begin
                cond_q <= (cond_q & ~hwdata[7:0]) | hwdata[15:8];
            end else begin
                cond_q <= cond_q | (cmd_go && cmd == IBTL_C_PDN ? 8'h00 : 8'h00);
            end
        end
    end

    // Remote/local and lockout state.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            remote_q <= 1'b0; // see RULE11
            ren_q <= 1'b0;
            llo_q <= 1'b0;
        end else if (cmd_go) begin
            unique case (cmd)
                IBTL_C_REN: ren_q <= 1'b1;
                IBTL_C_LLO: llo_q <= 1'b1; // see RULE13
                IBTL_C_NRE: begin
                    ren_q <= 1'b0;
                    llo_q <= 1'b0; // see RULE13
                    remote_q <= 1'b0;
                end
                // Remote is entered only when listen addressed with remote enabled.
                // Without a prior remote enable the device stays under panel control.
                IBTL_C_LAD: if (addressed && ren_q) remote_q <= 1'b1;
                // Go to local acts only on a listener and leaves lockout in force.
                // Lockout therefore survives a go-to-local and needs its own clear.
                IBTL_C_GTL: if (listen_q) remote_q <= 1'b0;
                default: remote_q <= remote_q;
            endcase
        end else if (key_rise && remote_q && !llo_q) begin
            remote_q <= 1'b0; // see RULE12 see RULE7
        end
    end

    // Talker and listener state; going local leaves these untouched.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            talk_q <= 1'b0;
            listen_q <= 1'b0;
        end else if (talk_only) begin
            talk_q <= 1'b1; // see RULE8
            listen_q <= 1'b0;
        end else if (cmd_go) begin
            unique case (cmd)
                IBTL_C_LAD: if (addressed) begin
                    listen_q <= 1'b1;
                    talk_q <= 1'b0; // see RULE17
                end
                // A talk address for another device unaddresses this talker.
                // Only one talker may drive the interface at a time.
                IBTL_C_TAD: talk_q <= addressed;
                // Unlisten and untalk are global and need no address match.
                IBTL_C_UNL: listen_q <= 1'b0;
                IBTL_C_UNT: talk_q <= 1'b0;
                // Interface clear drops both roles at once.
                IBTL_C_IFC: begin
                    talk_q <= 1'b0;
                    listen_q <= 1'b0;
                end
                default: talk_q <= talk_q;
            endcase
        end
    end

    // Loop auto-address, DDL control and parallel poll enable.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            auto_en_q <= IBTL_CFG_RST[0];
            auto_set_q <= 1'b0;
            // Parked at the factory preset until the loop assigns an address.
            // The switch address still rules while no auto address is set.
            auto_addr_q <= IBTL_PRESET_ADDR; // see RULE3
            pp_en_q <= 1'b0;
            ear_q <= 1'b0;
        end else if (cmd_go && loop_sel_i) begin
            unique case (cmd)
                IBTL_C_AAD: if (auto_en_q) begin
                    auto_addr_q <= arg; // see RULE4
                    auto_set_q <= 1'b1;
                end
                // Unconfigure falls back to the rear switch address.
                // The stored auto address is kept but no longer used.
                IBTL_C_AAU: auto_set_q <= 1'b0;
                // Auto addressing may only be switched while not auto addressed.
                IBTL_C_DDL: if (listen_q && !auto_set_q) auto_en_q <= arg[0]; // see RULE22
                IBTL_C_EAR: ear_q <= 1'b1;
                IBTL_C_ANOP: ear_q <= 1'b0;
                IBTL_C_PPE: pp_en_q <= 1'b1; // see RULE14
                IBTL_C_PPD: if (listen_q) pp_en_q <= 1'b0;
                IBTL_C_PPU: pp_en_q <= 1'b0;
                default: pp_en_q <= pp_en_q; // see RULE21
            endcase
        end
    end

    // Loop frame handling: foreign frames pass unchanged, AAD forwards n+1.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            frame_in_q <= 11'h000;
            frame_pend_q <= 1'b0;
            frame_out_o <= 11'h000;
            frame_out_valid_o <= 1'b0;
        end else begin
            frame_out_valid_o <= 1'b0;
            if (wr_q && wa_q == IBTL_FRAME_OFS && loop_sel_i) begin
                frame_in_q <= hwdata[IBTL_FRAME_BITS-1:0]; // see RULE24
                frame_pend_q <= 1'b1;
                frame_out_o <= hwdata[IBTL_FRAME_BITS-1:0];
                frame_out_valid_o <= 1'b1;
            end else if (cmd_go && cmd == IBTL_C_AAD && loop_sel_i) begin
                frame_out_o <= {6'h00, 5'(arg + 5'h01)};
                frame_out_valid_o <= 1'b1;
            end
        end
    end

    // Clear, trigger, talker send requests and loop service IDY.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dev_clear_o <= 1'b0;
            trig_pending_o <= 1'b0;
            loop_req_o <= '0;
        end else begin
            // The clear is a single-cycle pulse; universal clear needs no addressing.
            // A selected clear only reaches a device that is listen addressed.
            dev_clear_o <= cmd_go && (cmd == IBTL_C_DCL ||
                (cmd == IBTL_C_SDC && listen_q)); // see RULE15
            if (cmd_go && cmd == IBTL_C_GET && listen_q) begin
                trig_pending_o <= 1'b1; // see RULE16
            end else if (wr_q && wa_q == IBTL_CFG_OFS && hwdata[8]) begin
                trig_pending_o <= 1'b0;
            end
            loop_req_o.idy <= loop_sel_i && ear_q && srq_now; // see RULE19
            // One output format serves talk-only and addressed talking alike.
            if (cmd_go && talk_q && cmd == IBTL_C_SST) begin
                loop_req_o.send <= IBTL_SEND_STATUS; // see RULE18 see RULE9
            end else if (cmd_go && talk_q && loop_sel_i && cmd == IBTL_C_SDI) begin
                loop_req_o.send <= IBTL_SEND_DEVID;
            end else if (cmd_go && talk_q && loop_sel_i && cmd == IBTL_C_SAI) begin
                loop_req_o.send <= IBTL_SEND_ACCID;
            end else begin
                loop_req_o.send <= 2'h0;
            end
        end
    end

    // Indicators and the service line mirror the state flags; panel changes pass only in local.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            led_o <= '0;
            srq_line_o <= 1'b0;
            panel_accept_o <= 1'b1;
        end else begin
            led_o.remote <= remote_q; // see RULE5
            led_o.talk <= talk_q || talk_only; // see RULE25
            led_o.listen <= listen_q;
            led_o.srq <= srq_now;
            srq_line_o <= srq_now; // see RULE10
            panel_accept_o <= panel_ok && pin_s2_q[6]; // see RULE12
        end
    end
endmodule

/* ibtl_monitor.sv */
// Checker of indicator, clear, frame and loop behaviour seen at the top ports.
`timescale 1ns/100ps
module ibtl_monitor import ibtl_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [4:0] addr_switch_i,
    input wire logic panel_change_i,
    input wire logic loop_sel_i,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire ibtl_led_t led_o,
    input wire ibtl_req_t loop_req_o,
    input wire logic [10:0] frame_out_o,
    input wire logic frame_out_valid_o,
    input wire logic dev_clear_o,
    input wire logic panel_accept_o
);
    // Every property runs on the system clock and rests while reset is low.
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // A write address phase to the given offset followed by its data phase.
    sequence s_wr(logic [7:0] ofs);
        hsel && htrans[1] && hwrite && hready && haddr == ofs ##1 hready;
    endsequence
    // The indicators come up in local and stay there for a while.
    property p_local_reset;
        $rose(resetn_i) |-> (!led_o.remote) [*3];
    endproperty
    a_local_reset: assert property (p_local_reset) else $error("remote after reset");
    property p_go_local;
        $fell(led_o.remote) |-> $stable(led_o.talk) && $stable(led_o.listen) && $stable(led_o.srq);
    endproperty
    a_go_local: assert property (p_go_local) else $error("local changed other leds");
    property p_panel;
        (led_o.remote && panel_change_i) [*3] |-> !panel_accept_o;
    endproperty
    a_panel: assert property (p_panel) else $error("panel change taken in remote");
    property p_talk_only;
        (addr_switch_i == IBTL_TALK_ONLY_ADDR) [*8] |-> led_o.talk;
    endproperty
    a_talk_only: assert property (p_talk_only) else $error("talk led off in talk only");
    property p_untalk;
        $rose(led_o.listen) && addr_switch_i != IBTL_TALK_ONLY_ADDR |-> !led_o.talk;
    endproperty
    a_untalk: assert property (p_untalk) else $error("still talker after listen");
    property p_clr_pulse;
        dev_clear_o |=> !dev_clear_o;
    endproperty
    a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse too long");
    property p_frame;
        s_wr(IBTL_FRAME_OFS) |=> frame_out_valid_o && frame_out_o == $past(hwdata[10:0]);
    endproperty
    a_frame: assert property (p_frame) else $error("frame not passed on");
    property p_pdn;
        s_wr(IBTL_CMD_OFS) ##0 hwdata[4:0] == IBTL_C_PDN |=>
            ($stable(led_o) && loop_req_o.send == 2'h0) [*3];
    endproperty
    a_pdn: assert property (p_pdn) else $error("power down had effect");
    property p_bus_no_idy;
        (!loop_sel_i) [*2] |-> !loop_req_o.idy;
    endproperty
    a_bus_no_idy: assert property (p_bus_no_idy) else $error("identify on bus");
endmodule

/* ibtl_ctrl_model.sv */
// Controller model that issues interface commands over the register bus.
`timescale 1ns/100ps
module ibtl_ctrl_model (
    input wire logic sys_clk_i,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [7:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // The bus idles unselected from time zero.
    initial begin
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // One single word transfer; commands travel as coded words, never text.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge sys_clk_i);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge sys_clk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk_i); while (hready !== 1'b1);
        rd = hrdata;
        // Released lines show no stale value.
        hwdata <= ~wd;
        haddr <= ~a;
    endtask
endmodule

/* tb_instrument_bus_talker_listener.sv */
// Self-checking bench of the instrument bus talker/listener.
`timescale 1ns/100ps
module tb_instrument_bus_talker_listener import ibtl_pkg::*;;
    logic sys_clk_i, resetn_i, local_key_i, panel_change_i, loop_sel_i;
    logic hsel, hwrite, hready, hresp, srq_line_o, panel_accept_o, dev_clear_o, trig_pending_o;
    logic frame_out_valid_o;
    logic [4:0] addr_switch_i;
    logic [7:0] haddr;
    logic [1:0] htrans, last_send;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd, n_clr, cyc;
    logic [10:0] frame_out_o, last_frame;
    ibtl_led_t led_o, led_keep;
    ibtl_req_t loop_req_o;
    int n_mismatch = 0;
    int checks = 0;
    // Command, argument and expected {remote,talk,listen,srq}.
    localparam logic [13:0] ROWS [11] = '{
        {IBTL_C_REN, 5'h0a, 4'h0}, {IBTL_C_LAD, 5'h0a, 4'ha}, {IBTL_C_TAD, 5'h0a, 4'he},
        {IBTL_C_LAD, 5'h0a, 4'ha}, {IBTL_C_UNL, 5'h0a, 4'h8}, {IBTL_C_TAD, 5'h0a, 4'hc},
        {IBTL_C_LAD, 5'h03, 4'hc}, {IBTL_C_UNT, 5'h0a, 4'h8}, {IBTL_C_LAD, 5'h0a, 4'ha},
        {IBTL_C_GTL, 5'h0a, 4'h2}, {IBTL_C_IFC, 5'h0a, 4'h0}};
    localparam logic [4:0] SCMD [3] = '{IBTL_C_SST, IBTL_C_SDI, IBTL_C_SAI};
    localparam logic [1:0] SEXP [3] = '{IBTL_SEND_STATUS, IBTL_SEND_DEVID, IBTL_SEND_ACCID};
    ibtl_top i_dut (.sys_clk_i, .resetn_i, .addr_switch_i, .local_key_i, .panel_change_i,
        .loop_sel_i, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
        .hreadyout(hready), .hresp, .led_o, .srq_line_o, .panel_accept_o, .dev_clear_o,
        .trig_pending_o, .loop_req_o, .frame_out_o, .frame_out_valid_o);
    ibtl_ctrl_model i_ctrl (.sys_clk_i, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata);
    always #2 sys_clk_i = ~sys_clk_i;
    // Counts clear pulses, keeps the last send code and frame, and bounds the run.
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 32'h1;
        if (dev_clear_o === 1'b1) n_clr <= n_clr + 32'h1;
        if (loop_req_o.send !== 2'h0) last_send <= loop_req_o.send;
        if (frame_out_valid_o === 1'b1) last_frame <= frame_out_o;
        if (cyc == 32'h1388) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_ctrl.xfer(1'b1, a, d, rd);
        tick(3);
    endtask
    task automatic cmd(input logic [4:0] code, input logic [4:0] arg);
        wr(IBTL_CMD_OFS, {19'h0, arg, 3'h0, code});
    endtask
    task automatic press();
        local_key_i <= 1'b1;
        tick(2);
        local_key_i <= 1'b0;
        tick(3);
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Main sequence: reset, table of addressing commands, then the awkward cases.
    initial begin
        sys_clk_i = 1'b0;
        resetn_i = 1'b0;
        addr_switch_i = 5'h0a;
        {local_key_i, panel_change_i, loop_sel_i} = 3'h0;
        {cyc, n_clr, last_send, last_frame} = 77'h0;
        tick(16);
        resetn_i <= 1'b1;
        tick(4);
        chk({28'h0, led_o}, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        panel_change_i <= 1'b1;
        tick(4);
        chk({31'h0, panel_accept_o}, 32'h1);
        panel_change_i <= 1'b0;
        i_ctrl.xfer(1'b0, IBTL_MASK_OFS, 32'h0, rd);
        chk(rd, {24'h0, IBTL_MASK_RST});
        i_ctrl.xfer(1'b0, IBTL_CFG_OFS, 32'h0, rd);
        chk(rd, {30'h0, IBTL_CFG_RST});
        i_ctrl.xfer(1'b0, IBTL_STAT_OFS, 32'h0, rd);
        chk({27'h0, rd[12:8]}, 32'h0a);
        i_ctrl.xfer(1'b0, 8'h40, 32'h0, rd);
        chk(rd, 32'h0);
        foreach (ROWS[i]) begin
            cmd(ROWS[i][13:9], ROWS[i][8:4]);
            chk({28'h0, led_o}, {28'h0, ROWS[i][3:0]});
        end
        // Panel refused in remote; lockout holds the key off until cleared.
        cmd(IBTL_C_LAD, 5'h0a);
        panel_change_i <= 1'b1;
        tick(4);
        chk({31'h0, panel_accept_o}, 32'h0);
        cmd(IBTL_C_LLO, 5'h0);
        press();
        chk({31'h0, led_o.remote}, 32'h1);
        cmd(IBTL_C_NRE, 5'h0);
        chk({31'h0, led_o.remote}, 32'h0);
        chk({31'h0, panel_accept_o}, 32'h1);
        panel_change_i <= 1'b0;
        cmd(IBTL_C_REN, 5'h0);
        cmd(IBTL_C_LAD, 5'h0a);
        press();
        chk({31'h0, led_o.remote}, 32'h0);
        // Only masked conditions request service; unaddressing keeps the indicator.
        wr(IBTL_MASK_OFS, 32'h01);
        wr(IBTL_COND_OFS, 32'h0200);
        chk({31'h0, srq_line_o}, 32'h0);
        wr(IBTL_COND_OFS, 32'h0100);
        chk({31'h0, srq_line_o}, 32'h1);
        cmd(IBTL_C_IFC, 5'h0);
        chk({31'h0, led_o.srq}, 32'h1);
        wr(IBTL_COND_OFS, 32'h0001);
        // Both clears pulse once each; a trigger stays pending until cleared.
        cmd(IBTL_C_LAD, 5'h0a);
        cmd(IBTL_C_DCL, 5'h0);
        cmd(IBTL_C_SDC, 5'h0);
        chk(n_clr, 32'h2);
        cmd(IBTL_C_GET, 5'h0);
        chk({31'h0, trig_pending_o}, 32'h1);
        wr(IBTL_CFG_OFS, 32'h100);
        chk({31'h0, trig_pending_o}, 32'h0);
        // The loop-only device-id send is ignored on the bus, then all three sends work on the loop.
        cmd(IBTL_C_TAD, 5'h0a);
        cmd(IBTL_C_SDI, 5'h0);
        chk({30'h0, last_send}, 32'h0);
        loop_sel_i <= 1'b1;
        cmd(IBTL_C_AAD, 5'h01);
        i_ctrl.xfer(1'b0, IBTL_STAT_OFS, 32'h0, rd);
        chk({27'h0, rd[12:8]}, 32'h01);
        cmd(IBTL_C_TAD, 5'h01);
        for (int k = 0; k < 3; k++) begin
            cmd(SCMD[k], 5'h0);
            chk({30'h0, last_send}, {30'h0, SEXP[k]});
        end
        led_keep = led_o;
        cmd(IBTL_C_PDN, 5'h0);
        chk({28'h0, led_o}, {28'h0, led_keep});
        wr(IBTL_FRAME_OFS, 32'h5a5);
        chk({21'h0, last_frame}, 32'h5a5);
        cmd(IBTL_C_EAR, 5'h0);
        wr(IBTL_COND_OFS, 32'h0100);
        chk({31'h0, loop_req_o.idy}, 32'h1);
        addr_switch_i <= IBTL_TALK_ONLY_ADDR;
        cmd(IBTL_C_UNT, 5'h0);
        tick(8);
        chk({31'h0, led_o.talk}, 32'h1);
        report_and_stop();
    end
endmodule
bind ibtl_top ibtl_monitor u_mon (.sys_clk_i, .resetn_i, .addr_switch_i, .panel_change_i,
    .loop_sel_i, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .led_o, .loop_req_o,
    .frame_out_o, .frame_out_valid_o, .dev_clear_o, .panel_accept_o);
